/* File: rrm_mailbox.sv */
// Purpose: Request/response mailbox between controller words and field link
// Assumes: Controller words and link bytes are synchronous to clk
// Notes:   Reset stands for power-up and restarts the autobaud search
//
// Contract
// [R1] A request is sent only on the send bit's rising edge.
// [R2] A request that needs an answer waits for the response before finishing.
// [R3] No-answer request: only acknowledge set, command, length and present cleared.
// [R4] Status word: ack, undefined, present, five-bit length, command byte.
// [R5] Status low byte holds the command from the latest response.
// [R6] Acknowledge set after sending, held while send bit stays set.
// [R7] Acknowledge cleared when the send bit clears.
// [R8] Present flag set on stored response, cleared for no-answer requests.
// [R9] Length reports bytes actually stored, not bytes received.
// [R10] Bytes beyond buffer capacity are dropped.
// [R11] Reply data starts at the word after the status word.
// [R12] Even byte in low half, odd byte in high half.
// [R13] Control mode buffer is thirteen words, bytes 0 to 25.
// [R14] Status-poll mode buffer is three words, bytes 0 to 5.
// [R15] A new field unit answers address 200 at 4800 baud.
// [R16] Range position D polls addresses 196 to 210.
// [R17] Baud is detected automatically and redone after every power-up.
// [R18] Broadcast is command word then parameter word; 161 baud, 73 address.
// [R19] Controller gives the baud parameter as plain binary.
// [R20] Trigger rise sends broadcast; done bit raised while trigger stays set.
// [R21] Controller clears the trigger before the next broadcast.
// [R22] Broadcasts go to every unit, regardless of address.
// [R23] Reply fields settle before acknowledge rises.
module rrm_mailbox
    import rrm_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic                        send_bit,
    input  wire logic                        response_required,
    input  wire logic [7:0]                  request_cmd,
    input  wire logic [2:0]                  request_len,
    input  wire logic [5:0][7:0]             request_data,
    input  wire logic                        status_poll_mode,
    input  wire logic                        broadcast_trigger_bit,
    input  wire logic [15:0]                 broadcast_cmd,
    input  wire logic [15:0]                 broadcast_param,
    input  wire logic [3:0]                  range_select_switch,
    input  wire logic                        tx_ready,
    input  wire rrm_rx_t                     rx,
    input  wire logic                        rx_timeout,
    input  wire logic                        poll_ok,
    input  wire logic                        poll_fail,
    output logic      [15:0]                 reply_status_word,
    output logic      [CTRL_WORDS-1:0][15:0] controller_input_word,
    output logic                             broadcast_done_bit,
    output rrm_tx_t                          tx,
    output logic      [1:0]                  tx_baud_sel,
    output logic                             poll_req,
    output logic      [7:0]                  poll_addr
);

    // ==========================================================
    // State
    typedef struct packed {
        rrm_state_t  state;
        logic        send_prev;
        logic        trig_prev;
        logic        req_pend;
        logic        bc_pend;
        logic        need_rsp;
        logic        got_rsp;
        logic        first_rx;
        logic [7:0]  rsp_cmd;
        logic [2:0]  idx;
        logic [15:0] status;
        logic        bc_done;
        rrm_tx_t     tx;
    } rrm_st_t;

    rrm_st_t    st;
    rrm_st_t    next_st;
    logic       buf_clear;
    logic       buf_wr;
    logic [4:0] buf_count;
    logic       locked;
    logic [1:0] baud_sel;
    logic       tx_take;
    logic [2:0] req_len_eff;

    assign tx_take     = st.tx.valid && tx_ready;
    assign req_len_eff = (request_len > REQ_MAX_BYTES) ? REQ_MAX_BYTES : request_len;
    assign buf_wr      = (st.state == S_WAIT) && rx.valid && !st.first_rx; // R11
    assign buf_clear   = (st.state == S_IDLE) && st.req_pend;

    // ==========================================================
    // Reply buffer and autobaud
    rrm_reply_buf u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .clear     (buf_clear),
        .wr        (buf_wr),
        .wr_byte   (rx.data),
        .poll_mode (status_poll_mode), // R13 R14
        .words     (controller_input_word),
        .count     (buf_count)
    );

    rrm_autobaud u_ab (
        .clk                 (clk),
        .rst_n               (rst_n),
        .clk_en              (clk_en),
        .range_select_switch (range_select_switch),
        .poll_ok             (poll_ok),
        .poll_fail           (poll_fail),
        .poll_req            (poll_req),
        .poll_addr           (poll_addr),
        .baud_sel            (baud_sel),
        .locked              (locked)
    );

    // ==========================================================
    // Request and broadcast sequencing
    always_comb begin
        next_st           = st;
        next_st.send_prev = send_bit;
        next_st.trig_prev = broadcast_trigger_bit;
        if (send_bit && !st.send_prev) begin // R1
            next_st.req_pend = 1'b1;
        end
        if (broadcast_trigger_bit && !st.trig_prev) begin // R20
            next_st.bc_pend = 1'b1;
        end
        // Ack clears whenever the send bit is low, whatever the state
        if (!send_bit) begin
            next_st.status[STAT_ACK_BIT] = 1'b0; // R7
        end
        // Done follows trigger; fresh rise needed for the next broadcast
        if (!broadcast_trigger_bit) begin
            next_st.bc_done = 1'b0; // R21
        end
        if (tx_take) begin
            next_st.tx.valid = 1'b0;
        end
        unique case (st.state)
            S_IDLE: begin
                if (st.req_pend) begin
                    next_st.req_pend = send_bit && !st.send_prev;
                    next_st.need_rsp = response_required;
                    next_st.idx      = 3'h0;
                    next_st.tx       = '{valid: 1'b1, data: request_cmd, broadcast: 1'b0};
                    next_st.status[STAT_ACK_BIT] = 1'b0;
                    next_st.state    = S_REQ;
                end else if (st.bc_pend && locked) begin // R17
                    next_st.bc_pend = broadcast_trigger_bit && !st.trig_prev;
                    next_st.idx     = 3'h0;
                    next_st.tx      = '{valid: 1'b1, data: broadcast_cmd[15:8], broadcast: 1'b1}; // R22
                    next_st.state   = S_BC;
                end
            end
            S_REQ: begin
                if (tx_take) begin
                    if (st.idx == req_len_eff) begin
                        next_st.first_rx = 1'b1;
                        next_st.got_rsp  = 1'b0;
                        next_st.state    = st.need_rsp ? S_WAIT : S_POST; // R2
                    end else begin
                        next_st.idx      = st.idx + 3'h1;
                        next_st.tx.valid = 1'b1;
                        next_st.tx.data  = request_data[st.idx];
                    end
                end
            end
            S_WAIT: begin
                if (rx.valid) begin
                    next_st.first_rx = 1'b0;
                    if (st.first_rx) begin
                        next_st.rsp_cmd = rx.data; // R5
                    end
                    if (rx.last) begin
                        next_st.got_rsp = 1'b1;
                        next_st.state   = S_POST;
                    end
                end else if (rx_timeout) begin
                    next_st.got_rsp = 1'b0;
                    next_st.state   = S_POST;
                end
            end
            S_POST: begin
                // Fields settle one cycle ahead of the acknowledge
                next_st.status[STAT_UNDEF] = 1'b0; // R4
                if (st.got_rsp) begin
                    next_st.status[STAT_PRES_BIT]            = 1'b1; // R8
                    next_st.status[STAT_LEN_HI:STAT_LEN_LO]  = buf_count; // R9
                    next_st.status[STAT_CMD_HI:0]            = st.rsp_cmd; // R5
                end else begin
                    next_st.status[STAT_PRES_BIT]            = 1'b0; // R3
                    next_st.status[STAT_LEN_HI:STAT_LEN_LO]  = 5'h00;
                    next_st.status[STAT_CMD_HI:0]            = 8'h00;
                end
                next_st.state = S_ACK; // R23
            end
            S_ACK: begin
                if (send_bit) begin
                    next_st.status[STAT_ACK_BIT] = 1'b1; // R6
                end
                next_st.state = S_IDLE;
            end
            S_BC: begin
                if (tx_take) begin
                    if (st.idx == BC_LAST_IDX) begin
                        next_st.state = S_BCDONE;
                    end else begin
                        next_st.idx      = st.idx + 3'h1;
                        next_st.tx.valid = 1'b1;
                        unique case (st.idx) // R18
                            3'h0:    next_st.tx.data = broadcast_cmd[7:0];
                            3'h1:    next_st.tx.data = broadcast_param[15:8]; // R19
                            default: next_st.tx.data = broadcast_param[7:0];
                        endcase
                    end
                end
            end
            S_BCDONE: begin
                if (broadcast_trigger_bit) begin
                    next_st.bc_done = 1'b1; // R20
                end
                next_st.state = S_IDLE;
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.status <= STAT_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign reply_status_word  = st.status;
    assign broadcast_done_bit = st.bc_done;
    assign tx                 = st.tx;
    assign tx_baud_sel        = baud_sel; // R17

    // ==========================================================
    // Checks
    AST_RISE_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (clk_en && !(send_bit && !st.send_prev)) |=> !$rose(st.req_pend))
        else $error("request started without a send edge");

    AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && st.state == S_WAIT && !rx.valid && !rx_timeout) |=> st.state == S_WAIT) // R2
        else $error("left response wait without response");

    AST_NORSP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.status[STAT_ACK_BIT]) && !st.need_rsp |-> st.status[13:0] == 14'h0000) // R3
        else $error("no-answer request left reply fields set");

    AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (clk_en && st.status[STAT_ACK_BIT] && send_bit) |=> st.status[STAT_ACK_BIT])
        else $error("acknowledge dropped while send held");

    AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !send_bit) |=> !st.status[STAT_ACK_BIT]) // R7
        else $error("acknowledge not cleared after send cleared");

    AST_PRES_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.status[STAT_ACK_BIT]) && st.status[STAT_PRES_BIT] |->
        st.status[STAT_LEN_HI:STAT_LEN_LO] == buf_count) // R9
        else $error("reply length differs from stored count");

    AST_ACK_AFTER_POST: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.status[STAT_ACK_BIT]) |-> $past(st.state, 2) == S_POST) // R23
        else $error("acknowledge rose before reply fields settled");

    AST_BC_DONE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !broadcast_trigger_bit) |=> !st.bc_done) // R20
        else $error("broadcast done held after trigger cleared");

    AST_BC_LOCKED: assert property (@(posedge clk) disable iff (!rst_n)
        (st.tx.valid && st.tx.broadcast) |-> locked) // R17
        else $error("broadcast sent before baud lock");

    COV_ACK_RSP: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(st.status[STAT_ACK_BIT]) && st.status[STAT_PRES_BIT]);

    COV_ACK_NORSP: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(st.status[STAT_ACK_BIT]) && !st.status[STAT_PRES_BIT]);

    COV_BC_DONE: cover property (@(posedge clk) disable iff (!rst_n) $rose(st.bc_done));

    COV_TRUNC: cover property (@(posedge clk) disable iff (!rst_n)
        buf_wr && buf_count == (status_poll_mode ? POLL_BYTES : CTRL_BYTES));

endmodule : rrm_mailbox

/* File: rrm_pkg.sv */
// Purpose: Shared constants and types for the request/response mailbox
// Assumes: One clock, controller words and link bytes synchronous to clk
// Notes:   Bit positions are zero-based; status bit 16 is index 15
package rrm_pkg;

    // ==========================================================
    // Status word layout
    localparam int          STAT_W        = 16;
    localparam int          STAT_ACK_BIT  = 15;
    localparam int          STAT_UNDEF    = 14;
    localparam int          STAT_PRES_BIT = 13;
    localparam int          STAT_LEN_HI   = 12;
    localparam int          STAT_LEN_LO   = 8;
    localparam int          STAT_CMD_HI   = 7;
    localparam logic [15:0] STAT_RESET    = 16'h0000;

    // ==========================================================
    // Reply buffer geometry and request length limit
    localparam int          CTRL_WORDS    = 13;
    localparam int          POLL_WORDS    = 3;
    localparam logic [4:0]  CTRL_BYTES    = 5'h1a;
    localparam logic [4:0]  POLL_BYTES    = 5'h06;
    localparam logic [2:0]  REQ_MAX_BYTES = 3'h6;

    // ==========================================================
    // Link addressing, autobaud and broadcast
    localparam logic [3:0]  RANGE_D       = 4'hd;
    localparam logic [7:0]  ADDR_D_LO     = 8'hc4;
    localparam logic [7:0]  ADDR_D_HI     = 8'hd2;
    localparam logic [7:0]  FACTORY_ADDR  = 8'hc8;
    localparam int          FACTORY_BAUD  = 4800;
    localparam logic [1:0]  BAUD_LAST     = 2'h3;
    localparam logic [15:0] CMD_SET_BAUD  = 16'h00a1;
    localparam logic [15:0] CMD_SET_ADDR  = 16'h0049;
    localparam logic [15:0] BAUD_9600_VAL = 16'h2580;
    localparam logic [2:0]  BC_LAST_IDX   = 3'h3;

    // ==========================================================
    // Types
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } rrm_rx_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       broadcast;
    } rrm_tx_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_REQ    = 3'b001,
        S_WAIT   = 3'b010,
        S_POST   = 3'b011,
        S_ACK    = 3'b100,
        S_BC     = 3'b101,
        S_BCDONE = 3'b110
    } rrm_state_t;

    typedef enum logic [1:0] {
        AB_OFF  = 2'b00,
        AB_POLL = 2'b01,
        AB_WAIT = 2'b10,
        AB_LOCK = 2'b11
    } rrm_ab_state_t;

endpackage : rrm_pkg

/* File: rrm_reply_buf.sv */
// Purpose: Reply byte packing into controller input words
// Assumes: Writes arrive one byte per cycle at most
// Notes:   Excess bytes are dropped, count saturates at capacity
module rrm_reply_buf
    import rrm_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic                        clear,
    input  wire logic                        wr,
    input  wire logic [7:0]                  wr_byte,
    input  wire logic                        poll_mode,
    output logic      [CTRL_WORDS-1:0][15:0] words,
    output logic      [4:0]                  count
);

    typedef struct packed {
        logic [CTRL_WORDS-1:0][15:0] words;
        logic [4:0]                  count;
    } rrm_buf_st_t;

    rrm_buf_st_t                 st;
    rrm_buf_st_t                 next_st;
    logic [CTRL_WORDS-1:0][15:0] word_new;
    logic [4:0]                  cap;
    logic                        room;

    assign cap  = poll_mode ? POLL_BYTES : CTRL_BYTES;
    assign room = (st.count < cap);

    // ==========================================================
    // Per-word packing, even byte low and odd byte high
    for (genvar i = 0; i < CTRL_WORDS; i++) begin : g_word
        always_comb begin
            word_new[i] = st.words[i];
            if (wr && room && (st.count[4:1] == 4'(i))) begin // R11
                if (st.count[0]) begin // R12
                    word_new[i][15:8] = wr_byte;
                end else begin
                    word_new[i][7:0] = wr_byte;
                end
            end
        end
    end

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st = '0;
        end else if (wr && room) begin // R10
            next_st.words = word_new;
            next_st.count = st.count + 5'h01; // R9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign words = st.words;
    assign count = st.count;

    AST_BUF_CAP: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (clk_en && wr && !clear) |=> (st.count <= $past(cap)))
        else $error("reply count above buffer capacity");

endmodule : rrm_reply_buf

/* File: rrm_autobaud.sv */
// Purpose: Address range scan that locks onto the powered field unit
// Assumes: Link answers each poll with one ok or fail pulse
// Notes:   Only range position D scans; reset restarts the search
module rrm_autobaud
    import rrm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [3:0] range_select_switch,
    input  wire logic       poll_ok,
    input  wire logic       poll_fail,
    output logic            poll_req,
    output logic      [7:0] poll_addr,
    output logic      [1:0] baud_sel,
    output logic            locked
);

    typedef struct packed {
        rrm_ab_state_t state;
        logic          req;
        logic [7:0]    addr;
        logic [1:0]    baud;
    } rrm_ab_st_t;

    rrm_ab_st_t st;
    rrm_ab_st_t next_st;

    always_comb begin
        next_st     = st;
        next_st.req = 1'b0;
        unique case (st.state)
            AB_OFF: begin
                if (range_select_switch == RANGE_D) begin // R16
                    next_st.state = AB_POLL;
                    next_st.addr  = ADDR_D_LO;
                end
            end
            AB_POLL: begin
                next_st.req   = 1'b1;
                next_st.state = AB_WAIT;
            end
            AB_WAIT: begin
                if (poll_ok) begin // R17
                    next_st.state = AB_LOCK;
                end else if (poll_fail) begin
                    next_st.state = AB_POLL;
                    if (st.addr == ADDR_D_HI) begin // R16
                        next_st.addr = ADDR_D_LO;
                        next_st.baud = st.baud + 2'h1;
                    end else begin
                        next_st.addr = st.addr + 8'h01;
                    end
                end
            end
            AB_LOCK: begin
                next_st.state = AB_LOCK;
            end
        endcase
        if (range_select_switch != RANGE_D && st.state != AB_LOCK) begin
            next_st.state = AB_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{state: AB_OFF, req: 1'b0, addr: ADDR_D_LO, baud: 2'h0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign poll_req  = st.req;
    assign poll_addr = st.addr;
    assign baud_sel  = st.baud;
    assign locked    = (st.state == AB_LOCK);

    AST_POLL_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        st.req |-> (st.addr >= ADDR_D_LO && st.addr <= ADDR_D_HI)) // R16
        else $error("poll address outside range D");

endmodule : rrm_autobaud

/* File: rrm_link_model.sv */
// Purpose: Field link stand-in answering requests and polls
// Assumes: Bench sets the answer shape before each request
// Notes:   Ready drops at random so the mailbox sees stalls
module rrm_link_model
    import rrm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire rrm_tx_t    tx,
    input  wire logic       poll_req,
    input  wire logic [7:0] poll_addr,
    input  wire logic [3:0] n_tx,
    input  wire logic [1:0] mode,
    input  wire logic [4:0] rsp_n,
    output logic            tx_ready,
    output rrm_rx_t         rx,
    output logic            rx_timeout,
    output logic            poll_ok,
    output logic            poll_fail
);
    timeunit 1ns;
    timeprecision 100ps;
    int         cnt = 0;
    logic [7:0] pa;
    initial begin
        {tx_ready, rx, rx_timeout, poll_ok, poll_fail} = '0;
    end
    // ==========================================================
    // Request intake and answer
    always @(posedge clk) begin
        if (!rst_n)
            cnt = 0;
        else if (tx.valid && tx_ready && !tx.broadcast)
            cnt++;
        #1 tx_ready = 1'($urandom_range(1));
        rx = {1'b0, ~rx.data, 1'b0}; // Released line toggles, never holds
        rx_timeout = 1'b0;
        if (cnt == int'(n_tx)) begin
            cnt = 0;
            rx_timeout = (mode == 2'h2);
            for (int k = 0; mode == 2'h1 && k < int'(rsp_n); k++) begin
                rx = {1'b1, 8'(k * 37 + 60) ^ {4'h0, n_tx}, k == int'(rsp_n) - 1};
                @(posedge clk);
                #1;
            end
            rx.valid = 1'b0;
        end
    end
    // ==========================================================
    // Poll answers, one unit at the factory address
    always @(posedge clk) begin
        if (rst_n && poll_req) begin
            pa = poll_addr;
            repeat (2) @(posedge clk);
            #1 poll_ok = (pa == FACTORY_ADDR);
            poll_fail = !poll_ok;
            @(posedge clk);
            #1 {poll_ok, poll_fail} = 2'b00;
        end
    end
endmodule : rrm_link_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the request/response mailbox
// Assumes: Link model answers at the factory address
// Notes:   Inputs change 1 ns after the rising edge
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rrm_pkg::*;
    logic clk, rst_n, send_bit, rsp_req, poll_mode, trig, tx_ready, rx_timeout, poll_ok, poll_fail, done, poll_req;
    logic [7:0]                  cmd, poll_addr, rq[$], bq[$];
    logic [2:0]                  len;
    logic [5:0][7:0]             data;
    logic [15:0]                 bcmd, bparam, status;
    logic [CTRL_WORDS-1:0][15:0] words;
    logic [1:0]                  mode, baud;
    logic [3:0]                  n_tx;
    logic [4:0]                  rsp_n;
    rrm_tx_t                     tx;
    rrm_rx_t                     rx;
    int                          error_cnt = 0, compares = 0, cyc = 0;
    logic [7:0]                  cs[7] = '{8'h5b, 8'h01, 8'h5f, 8'h77, 8'h68, 8'ha5, 8'h41};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    rrm_mailbox rrm_mailbox_inst (.clk, .rst_n, .clk_en(1'b1), .send_bit, .response_required(rsp_req),
        .request_cmd(cmd), .request_len(len), .request_data(data), .status_poll_mode(poll_mode),
        .broadcast_trigger_bit(trig), .broadcast_cmd(bcmd), .broadcast_param(bparam), .range_select_switch(RANGE_D),
        .tx_ready, .rx, .rx_timeout, .poll_ok, .poll_fail, .reply_status_word(status), .controller_input_word(words),
        .broadcast_done_bit(done), .tx, .tx_baud_sel(baud), .poll_req, .poll_addr);
    rrm_link_model rrm_link_model_inst (.clk, .rst_n, .tx, .poll_req, .poll_addr, .n_tx, .mode, .rsp_n,
        .tx_ready, .rx, .rx_timeout, .poll_ok, .poll_fail);
    // ==========================================================
    // Checking helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    function automatic logic [7:0] rbyte(input int k);
        return 8'(k * 37 + 60) ^ {4'h0, n_tx};
    endfunction : rbyte
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    // Bounded wait for acknowledge (sel 0) or broadcast done (sel 1)
    task automatic wait_hi(input string what, input bit sel);
        for (int n = 0; (sel ? done : status[STAT_ACK_BIT]) !== 1'b1 && n < 500; n++) step();
        chk(what, 16'h1, 16'(sel ? done : status[STAT_ACK_BIT]));
    endtask : wait_hi
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            summarize();
        end
        if (tx.valid && tx_ready) begin
            if (tx.broadcast) bq.push_back(tx.data);
            else rq.push_back(tx.data);
        end
        if (poll_req) chk("poll_addr_range", 16'h1, 16'(poll_addr >= ADDR_D_LO && poll_addr <= ADDR_D_HI));
    end
    // ==========================================================
    // Request and broadcast sequences
    task automatic req(input logic [1:0] m, input logic pm, input logic [4:0] rn);
        int         st;
        logic [15:0] w;
        cmd = 8'($urandom);
        len = 3'($urandom);
        data = {$urandom, 16'($urandom)};
        rsp_req = (m != 2'h0);
        poll_mode = pm;
        mode = m;
        rsp_n = rn;
        n_tx = 4'(1 + (len > 3'h6 ? 6 : len));
        rq.delete();
        send_bit = 1'b1;
        wait_hi("ack_set", 1'b0);
        st = (m != 2'h1) ? 0 : (int'(rn) - 1 > (pm ? 6 : 26)) ? (pm ? 6 : 26) : int'(rn) - 1;
        chk("status", m == 2'h1 ? {3'b101, 5'(st), rbyte(0)} : 16'h8000, status);
        for (int j = 0; j < CTRL_WORDS; j++) begin
            w = 16'h0000;
            for (int h = 0; h < 2; h++) if (2 * j + h < st) w[8 * h +: 8] = rbyte(2 * j + h + 1);
            chk("reply_word", w, words[j]);
        end
        repeat (6) step();
        chk("req_count", 16'(n_tx), 16'(rq.size()));
        for (int k = 0; k < int'(n_tx); k++) chk("req_byte", k == 0 ? cmd : data[k - 1], rq[k]);
        chk("ack_held", 16'h1, 16'(status[STAT_ACK_BIT]));
        send_bit = 1'b0;
        step();
        chk("ack_clear", 16'h0, 16'(status[STAT_ACK_BIT]));
    endtask : req
    task automatic bcast(input logic [15:0] c, input logic [15:0] p);
        bcmd = c;
        bparam = p;
        bq.delete();
        trig = 1'b1;
        wait_hi("bc_done", 1'b1);
        chk("bc_cmd", c, {bq[0], bq[1]});
        chk("bc_param", p, {bq[2], bq[3]});
        trig = 1'b0;
        step();
        step();
        chk("bc_clear", 16'h0, 16'(done));
    endtask : bcast
    initial begin
        {rst_n, send_bit, rsp_req, poll_mode, trig, cmd, len, data, bcmd, bparam, mode, n_tx, rsp_n} = '0;
        void'($urandom(57779));
        repeat (3) step();
        chk("status_reset", STAT_RESET, status);
        chk("poll_addr_reset", 16'(ADDR_D_LO), 16'(poll_addr));
        rst_n = 1'b1;
        step();
        for (int i = 0; i < 7; i++) req(cs[i][7:6], cs[i][5], cs[i][4:0]);
        for (int i = 0; i < 12; i++) req(2'($urandom_range(2)), 1'($urandom), 5'($urandom_range(31, 1)));
        bcast(CMD_SET_BAUD, BAUD_9600_VAL);
        chk("baud_sel", 16'h0, 16'(baud));
        rst_n = 1'b0;
        step();
        chk("status_rst2", STAT_RESET, status);
        chk("poll_rst2", 16'(ADDR_D_LO), 16'(poll_addr));
        rst_n = 1'b1;
        bcast(CMD_SET_ADDR, 16'($urandom_range(255)));
        summarize();
    end
endmodule : tb_top
